// ### ep_dma_pkg.sv
/*
  Package for the external-port DMA channel: control field layout, modes,
  register offsets and the grouped signal carriers.
  Assumes a single 40 MHz system clock domain.
*/
package ep_dma_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned FIFO_DEPTH = 6;
  localparam int unsigned WORD_W = 48;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned COUNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EXT_INDEX = 8'h04;
  localparam logic [7:0] OFF_EXT_MODIFIER = 8'h08;
  localparam logic [7:0] OFF_EXT_COUNT = 8'h0C;
  localparam logic [7:0] OFF_INT_COUNT = 8'h10;

  // Control field positions
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_DIR_OUT = 1;
  localparam int unsigned BIT_HIGH_FIRST = 2;
  localparam int unsigned BIT_PACK_LO = 3;
  localparam int unsigned BIT_EXTERN = 5;
  localparam int unsigned BIT_HANDSHAKE_SEL = 6;
  localparam int unsigned BIT_MASTER = 7;
  localparam int unsigned BIT_PCNT_LO = 8;
  localparam int unsigned BIT_FLEVEL_LO = 12;

  localparam logic [1:0] PACK_NONE = 2'h0;
  localparam logic [1:0] PACK_16_32 = 2'h1;
  localparam logic [1:0] PACK_16_48 = 2'h2;
  localparam logic [1:0] PACK_32_48 = 2'h3;

  localparam logic [2:0] MODE_SLAVE = 3'h0;
  localparam logic [2:0] MODE_HANDSHAKE_SEL = 3'h2;
  localparam logic [2:0] MODE_EXT_HANDSHAKE_SEL = 3'h3;
  localparam logic [2:0] MODE_MASTER = 3'h4;
  localparam logic [2:0] MODE_PACED = 3'h6;

  typedef enum logic [2:0] {
    MD_SLAVE, MD_HANDSHAKE_SEL, MD_EXT_HANDSHAKE_SEL, MD_MASTER, MD_PACED, MD_RESERVED
  } dma_mode_t;

  typedef struct packed {
    logic channelEnable;
    logic dirOut;
    logic highHalfFirst;
    logic [1:0] packWidthSel;
    logic [2:0] modeBits;
  } chan_ctrl_t;

  // Short-word stream on the external side
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } ext_beat_t;

endpackage

// ### port_fifo.sv
/*
  Six-entry word FIFO with independent write and read ports.
  Assumes a synchronous writer and reader on sys_clk.
*/
`timescale 1ns/10ps
module port_fifo
  import ep_dma_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  // Write side
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  // Read side
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("port_fifo: bad DEPTH or WIDTH");
  end

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [LW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWr, doRd;

  assign wrReady = (st.cnt != LW'(DEPTH));
  assign rdValid = (st.cnt != '0);
  assign doWr = wrValid && wrReady;
  assign doRd = rdValid && rdReady;
  assign rdData = mem[st.rp];
  assign level = st.cnt;

  // one side writes while the other reads in the same cycle
  always_comb begin
    next_st = st;
    if (doWr) next_st.wp = (st.wp == PW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    if (doRd) next_st.rp = (st.rp == PW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    if (doWr && !doRd) next_st.cnt = st.cnt + 1'b1;
    else if (doRd && !doWr) next_st.cnt = st.cnt - 1'b1;
    if (flush) next_st = '0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doWr) mem[st.wp] <= wrData;
  end

  AST_NO_OVERFLOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.cnt <= LW'(DEPTH)) else $error("fifo level above depth");

endmodule

// ### ep_dma_channel.sv
/*
  External-port DMA channel: packing/unpacking between 16/32-bit external
  words and 32/48-bit internal words, external address generation, and
  mode selection. Registers on an APB slave.
  Assumes the internal memory path and external bus share sys_clk.
*/
`timescale 1ns/10ps
module ep_dma_channel
  import ep_dma_pkg::*;
#(
  parameter logic HANDSHAKE_SEL_CAPABLE = 1'b1,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal memory side
  output logic intReq,
  input wire logic intGrant,
  input wire logic [WORD_W-1:0] intRdData,
  output logic [WORD_W-1:0] intWrData,
  // External data bus
  input wire ext_beat_t extIn,
  output logic extInReady,
  output ext_beat_t extOut,
  input wire logic extOutReady,
  output logic [ADDR_W-1:0] extAddr,
  output logic extAddrValid,
  output logic extRdStrobe,
  output logic extWrStrobe,
  input wire logic extAck,
  // Handshake pins
  input wire logic dma_req_n,
  output logic dma_gnt_n
);
  initial begin
    if (DEPTH < 2) $error("ep_dma_channel: DEPTH too small");
  end

  typedef struct packed {
    chan_ctrl_t ctrl;
    logic [ADDR_W-1:0] extIndex;
    logic [ADDR_W-1:0] extModifier;
    logic [COUNT_W-1:0] extCount;
    logic [COUNT_W-1:0] intCount;
    logic [1:0] packCount;
    logic [WORD_W-1:0] shift;
    logic [15:0] spare;
    logic spareValid;
    logic reqSeen;
    logic [DATA_W-1:0] outData;
    logic outValid;
    logic [31:0] rdata;
  } chan_state_t;

  chan_state_t st, next_st;
  dma_mode_t mode;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady, flush;
  logic [WORD_W-1:0] fifoInData, fifoOutData;
  logic [$clog2(DEPTH+1)-1:0] fifoLevel;
  logic apbAcc, apbWr, extBeat, extActive, lastBeat, beatAllowed, unpackLast;
  logic [1:0] beatsPerWord;
  logic [DATA_W-1:0] beatData;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    unique case (st.ctrl.modeBits)
      MODE_SLAVE: mode = MD_SLAVE;
      MODE_HANDSHAKE_SEL: mode = HANDSHAKE_SEL_CAPABLE ? MD_HANDSHAKE_SEL : MD_RESERVED;
      MODE_EXT_HANDSHAKE_SEL: mode = HANDSHAKE_SEL_CAPABLE ? MD_EXT_HANDSHAKE_SEL : MD_RESERVED;
      MODE_MASTER: mode = MD_MASTER;
      MODE_PACED: mode = HANDSHAKE_SEL_CAPABLE ? MD_PACED : MD_RESERVED;
      default: mode = MD_RESERVED;
    endcase
  end

  // Beats per internal word; 32/48 alternates 2 and 1 beats (3 per 2 words)
  always_comb begin
    unique case (st.ctrl.packWidthSel)
      PACK_NONE: beatsPerWord = 2'd1;
      PACK_16_32: beatsPerWord = 2'd2;
      PACK_16_48: beatsPerWord = 2'd3;
      PACK_32_48: beatsPerWord = st.spareValid ? 2'd1 : 2'd2;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer gating per mode
  always_comb begin
    beatAllowed = 1'b0;
    unique case (mode)
      MD_SLAVE: beatAllowed = 1'b1;
      MD_HANDSHAKE_SEL, MD_EXT_HANDSHAKE_SEL: beatAllowed = !dma_req_n;
      MD_MASTER: beatAllowed = (st.extCount != '0);
      MD_PACED: beatAllowed = !dma_req_n && extAck && (st.extCount != '0);
      MD_RESERVED: beatAllowed = 1'b0;
    endcase
    beatAllowed = beatAllowed && st.ctrl.channelEnable;
  end

  assign extActive = beatAllowed;
  assign lastBeat = (st.packCount == beatsPerWord - 2'd1);
  // 32/48 unpack pops word one after one beat, keeping its low 16 bits for beat two
  assign unpackLast = (st.ctrl.packWidthSel == PACK_32_48) ? (st.spareValid == (st.packCount == 2'd1)) : lastBeat;

  // Short word taken from the head internal word when unpacking
  always_comb begin
    beatData = '0;
    unique case (st.ctrl.packWidthSel)
      PACK_NONE: beatData = fifoOutData[31:0];
      PACK_16_32: beatData[31:16] = (st.ctrl.highHalfFirst ^ (st.packCount == 2'd1)) ?
        fifoOutData[31:16] : fifoOutData[15:0];
      PACK_16_48: beatData[31:16] = st.ctrl.highHalfFirst ?
        fifoOutData[47 - 16*st.packCount -: 16] : fifoOutData[16*st.packCount +: 16];
      PACK_32_48: begin
        if (st.spareValid && st.packCount == 2'd0) beatData = {fifoOutData[15:0], st.spare};
        else beatData = fifoOutData[47:16];
      end
    endcase
  end

  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign flush = apbWr && (paddr == OFF_CTRL) && !pwdata[BIT_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    extBeat = 1'b0;
    fifoInValid = 1'b0;
    fifoInData = '0;
    fifoOutReady = 1'b0;
    next_st.reqSeen = !dma_req_n;
    if (!st.ctrl.dirOut) begin
      // Packing: external beats assemble internal words
      extBeat = extActive && extIn.valid && fifoInReady;
      if (extBeat) begin
        next_st.extIndex = st.extIndex + st.extModifier;
        next_st.extCount = st.extCount - 1'b1;
        unique case (st.ctrl.packWidthSel)
          PACK_NONE: fifoInData = {16'h0000, extIn.data};
          PACK_16_32: fifoInData = st.ctrl.highHalfFirst ?
            {16'h0000, st.shift[15:0], extIn.data[31:16]} : {16'h0000, extIn.data[31:16], st.shift[15:0]};
          PACK_16_48: fifoInData = st.ctrl.highHalfFirst ?
            {st.shift[31:0], extIn.data[31:16]} : {extIn.data[31:16], st.shift[31:0]};
          PACK_32_48: fifoInData = st.spareValid ? {extIn.data, st.spare} :
            {st.shift[31:0], extIn.data[15:0]};
        endcase
        if (lastBeat) begin
          fifoInValid = 1'b1;
          next_st.packCount = 2'd0;
          next_st.spareValid = (st.ctrl.packWidthSel == PACK_32_48) && !st.spareValid;
          next_st.spare = extIn.data[31:16];
        end else begin
          next_st.packCount = st.packCount + 2'd1;
          next_st.shift = {st.shift[31:0], extIn.data[31:16]};
          if (st.ctrl.packWidthSel == PACK_32_48) next_st.shift = {16'h0000, extIn.data};
        end
      end
    end else begin
      // Unpacking: internal words split into external beats
      extBeat = extActive && fifoOutValid && (!st.outValid || extOutReady);
      if (st.outValid && extOutReady) next_st.outValid = 1'b0;
      if (extBeat) begin
        next_st.outData = beatData;
        next_st.outValid = 1'b1;
        next_st.extIndex = st.extIndex + st.extModifier;
        next_st.extCount = st.extCount - 1'b1;
        if (unpackLast) begin
          fifoOutReady = 1'b1;
          next_st.packCount = 2'd0;
          next_st.spareValid = (st.ctrl.packWidthSel == PACK_32_48) && !st.spareValid;
          next_st.spare = fifoOutData[15:0];
        end else begin
          next_st.packCount = st.packCount + 2'd1;
        end
      end
    end
    if (intReq && intGrant && st.intCount != '0) next_st.intCount = st.intCount - 1'b1;
    // APB writes
    if (apbWr) begin
      unique case (paddr)
        OFF_CTRL: next_st.ctrl = '{channelEnable: pwdata[BIT_ENABLE], dirOut: pwdata[BIT_DIR_OUT],
          highHalfFirst: pwdata[BIT_HIGH_FIRST], packWidthSel: pwdata[BIT_PACK_LO +: 2],
          modeBits: {pwdata[BIT_MASTER], pwdata[BIT_HANDSHAKE_SEL], pwdata[BIT_EXTERN]}};
        OFF_EXT_INDEX: next_st.extIndex = pwdata;
        OFF_EXT_MODIFIER: next_st.extModifier = pwdata;
        OFF_EXT_COUNT: next_st.extCount = pwdata[COUNT_W-1:0];
        OFF_INT_COUNT: next_st.intCount = pwdata[COUNT_W-1:0];
        default: ;
      endcase
    end
    if (flush) begin
      next_st.packCount = 2'd0;
      next_st.spareValid = 1'b0;
      next_st.outValid = 1'b0;
    end
    // APB read data, registered in the setup cycle
    next_st.rdata = '0;
    if (psel && !penable) begin
      unique case (paddr)
        OFF_CTRL: begin
          next_st.rdata[BIT_ENABLE] = st.ctrl.channelEnable;
          next_st.rdata[BIT_DIR_OUT] = st.ctrl.dirOut;
          next_st.rdata[BIT_HIGH_FIRST] = st.ctrl.highHalfFirst;
          next_st.rdata[BIT_PACK_LO +: 2] = st.ctrl.packWidthSel;
          next_st.rdata[BIT_EXTERN] = st.ctrl.modeBits[0];
          next_st.rdata[BIT_HANDSHAKE_SEL] = st.ctrl.modeBits[1];
          next_st.rdata[BIT_MASTER] = st.ctrl.modeBits[2];
          next_st.rdata[BIT_PCNT_LO +: 2] = st.packCount;
          next_st.rdata[BIT_FLEVEL_LO +: 4] = 4'(fifoLevel);
        end
        OFF_EXT_INDEX: next_st.rdata = st.extIndex;
        OFF_EXT_MODIFIER: next_st.rdata = st.extModifier;
        OFF_EXT_COUNT: next_st.rdata[COUNT_W-1:0] = st.extCount;
        OFF_INT_COUNT: next_st.rdata[COUNT_W-1:0] = st.intCount;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer between internal and external sides
  port_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(flush),
    .wrValid(st.ctrl.dirOut ? (intReq && intGrant) : fifoInValid),
    .wrReady(fifoInReady),
    .wrData(st.ctrl.dirOut ? intRdData : fifoInData),
    .rdValid(fifoOutValid),
    .rdReady(st.ctrl.dirOut ? fifoOutReady : (intReq && intGrant)),
    .rdData(fifoOutData),
    .level(fifoLevel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Output fill starts at enable in any non-reserved mode with intCount nonzero, regardless of request pin
  assign intReq = st.ctrl.channelEnable && (mode != MD_RESERVED) && (st.intCount != '0) &&
    (st.ctrl.dirOut ? fifoInReady : fifoOutValid);
  assign intWrData = fifoOutData;
  assign extInReady = !st.ctrl.dirOut && extActive && fifoInReady;
  assign extOut = '{valid: st.outValid, data: st.outData};
  assign extAddr = st.extIndex;
  assign extAddrValid = extBeat && (mode == MD_MASTER || mode == MD_PACED || mode == MD_EXT_HANDSHAKE_SEL);
  assign extRdStrobe = extBeat && !st.ctrl.dirOut && (mode == MD_MASTER || mode == MD_PACED);
  assign extWrStrobe = extBeat && st.ctrl.dirOut && (mode == MD_MASTER || mode == MD_PACED);
  assign dma_gnt_n = !(extBeat && (mode == MD_HANDSHAKE_SEL || mode == MD_EXT_HANDSHAKE_SEL));
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = apbAcc && (paddr > OFF_INT_COUNT || paddr[1:0] != 2'b00);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RESERVED_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == MD_RESERVED |-> !intReq && !extBeat) else $error("reserved mode active");
  AST_GNT_NEEDS_REQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !dma_gnt_n |-> !dma_req_n) else $error("grant without request");
  AST_PACED_NO_GNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == MD_PACED |-> dma_gnt_n) else $error("grant in paced master");
  AST_MASTER_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MD_MASTER && st.extCount == '0) |-> !extBeat) else $error("beat at zero count");
  AST_INDEX_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (extBeat && !apbWr) |=> extAddr == $past(st.extIndex) + $past(st.extModifier))
    else $error("index not advanced");
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (extBeat && !apbWr) |=> st.extCount == $past(st.extCount) - 1'b1) else $error("count not stepped");
  AST_PCOUNT_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.packCount < 2'd3) else $error("pack count out of range");
  AST_OUT_FILL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.ctrl.channelEnable && st.ctrl.dirOut && mode != MD_RESERVED && fifoInReady && st.intCount != '0)
    |-> intReq) else $error("output fill not requested");
  AST_PACED_STRETCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MD_PACED && !extAck) |-> !extRdStrobe && !extWrStrobe) else $error("strobe without ack");
  AST_NONE_ONE_BEAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.ctrl.packWidthSel == PACK_NONE |-> st.packCount == 2'd0) else $error("no-pack count moved");
  AST_FLUSH_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flush |=> st.packCount == 2'd0 && !st.spareValid) else $error("packer not flushed");
  AST_UNPACK_SPLIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (extBeat && st.ctrl.dirOut && st.ctrl.packWidthSel == PACK_32_48 && !st.spareValid) |-> fifoOutReady)
    else $error("first 32/48 word not popped");
  AST_SLAVE_DRAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st.ctrl.channelEnable && mode == MD_SLAVE && !st.ctrl.dirOut && fifoOutValid && st.intCount != '0)
    |-> intReq) else $error("slave input not drained");

endmodule

// ### ext_dev_model.sv
/*
  Far-side model of the external bus: a device that writes short-word beats
  into the channel, reads beats out of it and drives the request pin.
  Assumes the channel's single sys_clk and the bench calling send() and
  steering reqAssert, stallOut and ackHold.
*/
`timescale 1ns/10ps
module ext_dev_model
  import ep_dma_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic reqAssert,
  input wire logic stallOut,
  input wire logic ackHold,
  // Channel external side
  output ext_beat_t extIn,
  input wire logic extInReady,
  input wire ext_beat_t extOut,
  output logic extOutReady,
  input wire logic [ADDR_W-1:0] extAddr,
  input wire logic extAddrValid,
  output logic extAck,
  output logic dma_req_n,
  input wire logic dma_gnt_n
);
  logic [31:0] got[$];
  logic [31:0] gotAddr[$];
  logic lastGnt;

  initial begin
    extIn = '0;
    lastGnt = 1'b1;
  end

  // Bench stretches paced accesses by holding ack low
  assign extAck = !ackHold;

  ////////////////////////////////////////////////////////////////////////////
  // Request pin stays high unless the bench asks for a transfer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_n <= 1'b1;
      extOutReady <= 1'b0;
    end else begin
      dma_req_n <= !reqAssert;
      extOutReady <= !stallOut;
    end
  end

  always @(posedge sys_clk) begin
    if (extOut.valid && extOutReady) begin
      got.push_back(extOut.data);
    end
    if (extAddrValid) begin
      gotAddr.push_back(extAddr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One beat, held until accepted; released data is inverted, never stale
  task automatic send(input logic [31:0] d);
    @(posedge sys_clk);
    extIn <= '{valid: 1'b1, data: d};
    do @(posedge sys_clk); while (extInReady !== 1'b1);
    lastGnt = dma_gnt_n;
    extIn <= '{valid: 1'b0, data: ~d};
  endtask
endmodule

// ### ext_port_dma_pack_modes_tb.sv
/*
  Self-checking bench for the external-port DMA channel: APB register
  access, packing lanes, unpacking, address generation and mode selection.
  Assumes ext_dev_model on the external side; the bench plays internal memory.
*/
`timescale 1ns/10ps
module ext_port_dma_pack_modes_tb
  import ep_dma_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, intReq, extInReady, extOutReady, extAddrValid;
  logic intGrant;
  logic [WORD_W-1:0] intRdData, intWrData;
  ext_beat_t extIn, extOut;
  logic [ADDR_W-1:0] extAddr;
  logic extRdStrobe, extWrStrobe, extAck, dma_req_n, dma_gnt_n;
  logic reqAssert, stallOut, ackHold;
  logic [31:0] rd;
  logic err;
  logic [47:0] w;
  int err_count = 0, checks = 0, cycles = 0, rdStrobes = 0, wrStrobes = 0;

  always #12.5 sys_clk = ~sys_clk;

  ep_dma_channel #(.HANDSHAKE_SEL_CAPABLE(1'b1), .DEPTH(FIFO_DEPTH)) ep_dma_channel_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intReq(intReq), .intGrant(intGrant), .intRdData(intRdData), .intWrData(intWrData),
    .extIn(extIn), .extInReady(extInReady), .extOut(extOut), .extOutReady(extOutReady),
    .extAddr(extAddr), .extAddrValid(extAddrValid), .extRdStrobe(extRdStrobe),
    .extWrStrobe(extWrStrobe), .extAck(extAck), .dma_req_n(dma_req_n), .dma_gnt_n(dma_gnt_n));

  ext_dev_model ext_dev_model_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reqAssert(reqAssert), .stallOut(stallOut), .ackHold(ackHold),
    .extIn(extIn), .extInReady(extInReady), .extOut(extOut), .extOutReady(extOutReady),
    .extAddr(extAddr), .extAddrValid(extAddrValid), .extAck(extAck),
    .dma_req_n(dma_req_n), .dma_gnt_n(dma_gnt_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (extRdStrobe === 1'b1) rdStrobes++;
    if (extWrStrobe === 1'b1) wrStrobes++;
    // Whole run needs a few hundred cycles
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Control word: mode is {initiator, handshake, outside}
  task automatic ctrl(input logic [2:0] mode, input logic [1:0] pk, input logic hf, input logic dir);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_INT_COUNT, 32'h4);
    apb(1'b1, OFF_CTRL, {24'h0, mode, pk, hf, dir, 1'b1});
  endtask

  // One internal word: hands wd in, returns the word the channel offered
  task automatic int_xfer(input logic [47:0] wd, output logic [47:0] got);
    do @(posedge sys_clk); while (intReq !== 1'b1);
    intGrant <= 1'b1;
    intRdData <= wd;
    @(posedge sys_clk);
    got = intWrData;
    intGrant <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    intGrant <= 1'b0;
    intRdData <= '0;
    reqAssert <= 1'b0;
    stallOut <= 1'b0;
    ackHold <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values and a refused access
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk("reset reg", {16'h0, rd}, 48'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", {47'h0, err}, 48'h1);
    // Mode table: output channel fills at once unless reserved
    for (int m = 0; m < 8; m++) begin
      ctrl(3'(m), PACK_NONE, 1'b0, 1'b1);
      repeat (3) @(negedge sys_clk);
      chk("mode intReq", {47'h0, intReq}, {47'h0, !(m == 1 || m == 5 || m == 7)});
    end
    // 16 to 32, both orders, pack count after the first half
    for (int hf = 0; hf < 2; hf++) begin
      ctrl(MODE_SLAVE, PACK_16_32, 1'(hf), 1'b0);
      ext_dev_model_i.send(32'h1234_0000);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("pack count", {46'h0, rd[9:8]}, 48'h1);
      ext_dev_model_i.send(32'h5678_0000);
      int_xfer(48'h0, w);
      chk("16/32 word", {16'h0, w[31:0]}, hf ? 48'h1234_5678 : 48'h5678_1234);
    end
    // 16 to 48, upper short word first
    ctrl(MODE_SLAVE, PACK_16_48, 1'b1, 1'b0);
    ext_dev_model_i.send(32'hAAAA_0000);
    ext_dev_model_i.send(32'hBBBB_0000);
    ext_dev_model_i.send(32'hCCCC_0000);
    int_xfer(48'h0, w);
    chk("16/48 word", w, 48'hAAAA_BBBB_CCCC);
    // 32 to 48 lane table, order bit set but ignored
    ctrl(MODE_SLAVE, PACK_32_48, 1'b1, 1'b0);
    ext_dev_model_i.send(32'h1111_2222);
    ext_dev_model_i.send(32'h6666_3333);
    ext_dev_model_i.send(32'h4444_5555);
    int_xfer(48'h0, w);
    chk("32/48 word1", w, 48'h1111_2222_3333);
    int_xfer(48'h0, w);
    chk("32/48 word2", w, 48'h4444_5555_6666);
    // Handshake: held off while request pin idle, grant marks the beat
    ctrl(MODE_HANDSHAKE_SEL, PACK_NONE, 1'b0, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk("hs idle ready", {47'h0, extInReady}, 48'h0);
    reqAssert <= 1'b1;
    ext_dev_model_i.send(32'h0BAD_F00D);
    chk("hs grant", {47'h0, ext_dev_model_i.lastGnt}, 48'h0);
    reqAssert <= 1'b0;
    int_xfer(48'h0, w);
    chk("hs word", {16'h0, w[31:0]}, 48'h0BAD_F00D);
    // Master output, unpack 16/32 low half first, stalled reader
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_EXT_INDEX, 32'h100);
    apb(1'b1, OFF_EXT_MODIFIER, 32'h4);
    apb(1'b1, OFF_EXT_COUNT, 32'h2);
    apb(1'b1, OFF_INT_COUNT, 32'h1);
    stallOut <= 1'b1;
    ext_dev_model_i.gotAddr.delete();
    apb(1'b1, OFF_CTRL, {24'h0, MODE_MASTER, PACK_16_32, 1'b0, 1'b1, 1'b1});
    int_xfer(48'h0000_AAAA_5555, w);
    repeat (5) @(negedge sys_clk);
    chk("stalled beats", 48'(ext_dev_model_i.got.size()), 48'h0);
    stallOut <= 1'b0;
    repeat (20) @(negedge sys_clk);
    chk("beat count", 48'(ext_dev_model_i.got.size()), 48'h2);
    chk("write strobes", 48'(wrStrobes), 48'h2);
    if (ext_dev_model_i.got.size() == 2) begin
      chk("beat1", {32'h0, ext_dev_model_i.got[0][31:16]}, 48'h5555);
      chk("beat2", {32'h0, ext_dev_model_i.got[1][31:16]}, 48'hAAAA);
    end
    if (ext_dev_model_i.gotAddr.size() == 2) begin
      chk("addr1", {16'h0, ext_dev_model_i.gotAddr[0]}, 48'h100);
      chk("addr2", {16'h0, ext_dev_model_i.gotAddr[1]}, 48'h104);
    end else begin
      chk("addr count", 48'(ext_dev_model_i.gotAddr.size()), 48'h2);
    end
    // Paced master input: low ack holds it off, no grant, read strobe marks the beat
    apb(1'b1, OFF_EXT_COUNT, 32'h1);
    ctrl(MODE_PACED, PACK_NONE, 1'b0, 1'b0);
    ackHold <= 1'b1;
    reqAssert <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("paced held", {47'h0, extInReady}, 48'h0);
    @(posedge sys_clk);
    ackHold <= 1'b0;
    ext_dev_model_i.send(32'h1357_2468);
    chk("paced grant", {47'h0, ext_dev_model_i.lastGnt}, 48'h1);
    reqAssert <= 1'b0;
    int_xfer(48'h0, w);
    chk("paced word", {16'h0, w[31:0]}, 48'h1357_2468);
    chk("read strobes", 48'(rdStrobes), 48'h1);
    apb(1'b0, OFF_EXT_COUNT, 32'h0);
    chk("ext count end", {16'h0, rd}, 48'h0);
    conclude();
  end
endmodule
